// ==== literal_bit_alu_execute.v ====
`timescale 1ns/1ps
`include "literal_bit_alu_map.vh"

// What this block does
// - add literal to acc, update c dc z
// - add file to acc, update c dc z
// - destination bit picks acc or file
// - and literal into acc, zero flag only
// - and file with acc, zero flag only
// - clear indexed file bit, flags unchanged
// - set indexed file bit, flags unchanged
// - bit one skips next, three cycles
// - bit zero skips next, three cycles
module literal_bit_alu_execute #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7,
    parameter BIDX_W = 3
) (
    input wire CLK_SYS_IN,
    input wire RST_IN,
    input wire CE_IN,
    input wire INSTR_VALID_IN,
    input wire [`LBA_INSTR_W-1:0] INSTR_IN,
    input wire [DATA_W-1:0] FILE_RD_DATA_IN,
    output reg READY_OUT,
    output reg FILE_RD_EN_OUT,
    output reg [ADDR_W-1:0] FILE_RD_ADDR_OUT,
    output reg FILE_WR_EN_OUT,
    output reg [ADDR_W-1:0] FILE_WR_ADDR_OUT,
    output reg [DATA_W-1:0] FILE_WR_DATA_OUT,
    output reg [DATA_W-1:0] ACC_OUT,
    output reg CARRY_FLAG_OUT,
    output reg DIGIT_CARRY_FLAG_OUT,
    output reg ZERO_FLAG_OUT,
    output reg DONE_OUT,
    output reg SKIP_OUT,
    output reg DISCARD_OUT,
    output reg UNSUPPORTED_OUT
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_READ = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function is_add_lit;
        input [`LBA_INSTR_W-1:0] i;
        begin
            is_add_lit = (i[`LBA_ADD_LITERAL_TO_ACC_HI:`LBA_ADD_LITERAL_TO_ACC_LO] == `LBA_OP_ADD_LIT_ACC);
        end
    endfunction

    function is_and_lit;
        input [`LBA_INSTR_W-1:0] i;
        begin
            is_and_lit = (i[`LBA_BYTE_OP_HI:`LBA_BYTE_OP_LO] == `LBA_OP_AND_LIT_ACC);
        end
    endfunction

    function is_add_file;
        input [`LBA_INSTR_W-1:0] i;
        begin
            is_add_file = (i[`LBA_BYTE_OP_HI:`LBA_BYTE_OP_LO] == `LBA_OP_ADD_ACC_FILE);
        end
    endfunction

    function is_and_file;
        input [`LBA_INSTR_W-1:0] i;
        begin
            is_and_file = (i[`LBA_BYTE_OP_HI:`LBA_BYTE_OP_LO] == `LBA_OP_AND_ACC_FILE);
        end
    endfunction

    function is_bit_op;
        input [`LBA_INSTR_W-1:0] i;
        begin
            is_bit_op = (i[`LBA_GRP_HI:`LBA_GRP_LO] == `LBA_GRP_BIT);
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [1:0] state_ff, nxt_state;
    reg [`LBA_INSTR_W-1:0] instr_ff, nxt_instr;
    reg skip_pend_ff, nxt_skip_pend;
    reg nxt_ready, nxt_rd_en, nxt_wr_en;
    reg [ADDR_W-1:0] nxt_rd_addr, nxt_wr_addr;
    reg [DATA_W-1:0] nxt_wr_data, nxt_acc;
    reg nxt_carry, nxt_dc, nxt_zero;
    reg nxt_done, nxt_skip, nxt_discard, nxt_unsup;

    reg [1:0] alu_op;
    reg [`LBA_INSTR_W-1:0] cur;
    reg [DATA_W-1:0] alu_opnd;
    wire [DATA_W-1:0] alu_res;
    wire alu_c, alu_dc, alu_z;
    wire [BIDX_W-1:0] bit_idx;
    wire tested_bit;

    assign bit_idx = cur_bidx(state_ff, instr_ff, INSTR_IN);
    assign tested_bit = FILE_RD_DATA_IN[bit_idx];

    function [BIDX_W-1:0] cur_bidx;
        input [1:0] st;
        input [`LBA_INSTR_W-1:0] held;
        input [`LBA_INSTR_W-1:0] fresh;
        begin
            if (st == ST_IDLE) begin
                cur_bidx = fresh[`LBA_BIDX_HI:`LBA_BIDX_LO];
            end else begin
                cur_bidx = held[`LBA_BIDX_HI:`LBA_BIDX_LO];
            end
        end
    endfunction

    lba_alu_unit #(
        .DATA_W(DATA_W),
        .BIDX_W(BIDX_W)
    ) u_alu (
        .op_in(alu_op),
        .acc_in(ACC_OUT),
        .opnd_in(alu_opnd),
        .bit_idx_in(bit_idx),
        .result_out(alu_res),
        .carry_out(alu_c),
        .digit_carry_out(alu_dc),
        .zero_out(alu_z)
    );

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_instr = instr_ff;
        nxt_skip_pend = skip_pend_ff;
        nxt_rd_en = 1'b0;
        nxt_rd_addr = FILE_RD_ADDR_OUT;
        nxt_wr_en = 1'b0;
        nxt_wr_addr = FILE_WR_ADDR_OUT;
        nxt_wr_data = FILE_WR_DATA_OUT;
        nxt_acc = ACC_OUT;
        nxt_carry = CARRY_FLAG_OUT;
        nxt_dc = DIGIT_CARRY_FLAG_OUT;
        nxt_zero = ZERO_FLAG_OUT;
        nxt_done = 1'b0;
        nxt_skip = 1'b0;
        nxt_discard = 1'b0;
        nxt_unsup = 1'b0;
        alu_op = `LBA_ALU_ADD;
        alu_opnd = FILE_RD_DATA_IN;
        cur = (state_ff == ST_IDLE) ? INSTR_IN : instr_ff;
        if (is_add_file(cur) || is_add_lit(cur)) begin
            alu_op = `LBA_ALU_ADD;
        end else if (is_and_file(cur) || is_and_lit(cur)) begin
            alu_op = `LBA_ALU_AND;
        end else if (cur[`LBA_BIT_OP_HI:`LBA_BIT_OP_LO] == `LBA_BOP_CLEAR) begin
            alu_op = `LBA_ALU_BCLR;
        end else begin
            alu_op = `LBA_ALU_BSET;
        end
        if (state_ff == ST_IDLE) begin
            alu_opnd = INSTR_IN[`LBA_LIT_HI:`LBA_LIT_LO];
        end
        case (state_ff)
            ST_IDLE: begin
                if (INSTR_VALID_IN) begin
                    nxt_instr = INSTR_IN;
                    if (skip_pend_ff) begin
                        // the discarded word spends its cycle as a no-operation
                        nxt_skip_pend = 1'b0;
                        nxt_discard = 1'b1;
                        nxt_done = 1'b1;
                    end else if (is_add_lit(INSTR_IN)) begin
                        nxt_acc = alu_res;
                        nxt_carry = alu_c;
                        nxt_dc = alu_dc;
                        nxt_zero = alu_z;
                        nxt_done = 1'b1;
                    end else if (is_and_lit(INSTR_IN)) begin
                        nxt_acc = alu_res;
                        nxt_zero = alu_z;
                        nxt_done = 1'b1;
                    end else if (is_add_file(INSTR_IN) || is_and_file(INSTR_IN) ||
                                 is_bit_op(INSTR_IN)) begin
                        // file operand always fetched first, even for bit writes
                        nxt_rd_en = 1'b1;
                        nxt_rd_addr = INSTR_IN[`LBA_FADDR_HI:`LBA_FADDR_LO];
                        nxt_state = ST_READ;
                    end else begin
                        nxt_unsup = 1'b1;
                        nxt_done = 1'b1;
                    end
                end
            end
            ST_READ: begin
                nxt_state = ST_EXEC;
            end
            ST_EXEC: begin
                nxt_state = ST_IDLE;
                nxt_done = 1'b1;
                nxt_wr_addr = instr_ff[`LBA_FADDR_HI:`LBA_FADDR_LO];
                if (is_bit_op(instr_ff)) begin
                    case (instr_ff[`LBA_BIT_OP_HI:`LBA_BIT_OP_LO])
                        `LBA_BOP_CLEAR: begin
                            nxt_wr_en = 1'b1;
                            nxt_wr_data = alu_res;
                        end
                        `LBA_BOP_SET: begin
                            nxt_wr_en = 1'b1;
                            nxt_wr_data = alu_res;
                        end
                        `LBA_BOP_SKIP_ONE: begin
                            nxt_skip = tested_bit;
                            nxt_skip_pend = tested_bit;
                        end
                        `LBA_BOP_SKIP_ZERO: begin
                            nxt_skip = ~tested_bit;
                            nxt_skip_pend = ~tested_bit;
                        end
                        default: begin
                            nxt_skip = 1'b0;
                        end
                    endcase
                end else begin
                    if (is_add_file(instr_ff)) begin
                        nxt_carry = alu_c;
                        nxt_dc = alu_dc;
                    end
                    nxt_zero = alu_z;
                    if (instr_ff[`LBA_DEST_BIT] == `LBA_DEST_FILE) begin
                        nxt_wr_en = 1'b1;
                        nxt_wr_data = alu_res;
                    end else begin
                        nxt_acc = alu_res;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_ready = (nxt_state == ST_IDLE);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // ce low freezes everything, pulses included, so a stalled core sees them held
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_ff <= ST_IDLE;
            instr_ff <= `LBA_RST_INSTR;
            skip_pend_ff <= 1'b0;
            READY_OUT <= 1'b0;
            FILE_RD_EN_OUT <= 1'b0;
            FILE_RD_ADDR_OUT <= `LBA_RST_ADDR;
            FILE_WR_EN_OUT <= 1'b0;
            FILE_WR_ADDR_OUT <= `LBA_RST_ADDR;
            FILE_WR_DATA_OUT <= `LBA_RST_DATA;
            ACC_OUT <= `LBA_RST_ACC;
            CARRY_FLAG_OUT <= `LBA_RST_FLAG;
            DIGIT_CARRY_FLAG_OUT <= `LBA_RST_FLAG;
            ZERO_FLAG_OUT <= `LBA_RST_FLAG;
            DONE_OUT <= 1'b0;
            SKIP_OUT <= 1'b0;
            DISCARD_OUT <= 1'b0;
            UNSUPPORTED_OUT <= 1'b0;
        end else if (CE_IN) begin
            state_ff <= nxt_state;
            instr_ff <= nxt_instr;
            skip_pend_ff <= nxt_skip_pend;
            READY_OUT <= nxt_ready;
            FILE_RD_EN_OUT <= nxt_rd_en;
            FILE_RD_ADDR_OUT <= nxt_rd_addr;
            FILE_WR_EN_OUT <= nxt_wr_en;
            FILE_WR_ADDR_OUT <= nxt_wr_addr;
            FILE_WR_DATA_OUT <= nxt_wr_data;
            ACC_OUT <= nxt_acc;
            CARRY_FLAG_OUT <= nxt_carry;
            DIGIT_CARRY_FLAG_OUT <= nxt_dc;
            ZERO_FLAG_OUT <= nxt_zero;
            DONE_OUT <= nxt_done;
            SKIP_OUT <= nxt_skip;
            DISCARD_OUT <= nxt_discard;
            UNSUPPORTED_OUT <= nxt_unsup;
        end
    end

endmodule

// ==== literal_bit_alu_map.vh ====
`ifndef LITERAL_BIT_ALU_MAP_VH
`define LITERAL_BIT_ALU_MAP_VH

// ----------------------------------------
// instruction word layout
// ----------------------------------------
`define LBA_INSTR_W 14
`define LBA_GRP_HI 13
`define LBA_GRP_LO 12
`define LBA_BYTE_OP_HI 13
`define LBA_BYTE_OP_LO 8
`define LBA_LIT_HI 7
`define LBA_LIT_LO 0
`define LBA_DEST_BIT 7
`define LBA_FADDR_HI 6
`define LBA_FADDR_LO 0
`define LBA_BIT_OP_HI 11
`define LBA_BIT_OP_LO 10
`define LBA_BIDX_HI 9
`define LBA_BIDX_LO 7
`define LBA_ADD_LITERAL_TO_ACC_HI 13
`define LBA_ADD_LITERAL_TO_ACC_LO 9

// ----------------------------------------
// opcodes
// ----------------------------------------
`define LBA_OP_ADD_ACC_FILE 6'h07
`define LBA_OP_AND_ACC_FILE 6'h05
`define LBA_OP_AND_LIT_ACC 6'h39
`define LBA_OP_ADD_LIT_ACC 5'h1F
`define LBA_GRP_BIT 2'h1
`define LBA_BOP_CLEAR 2'h0
`define LBA_BOP_SET 2'h1
`define LBA_BOP_SKIP_ZERO 2'h2
`define LBA_BOP_SKIP_ONE 2'h3

// ----------------------------------------
// alu function select
// ----------------------------------------
`define LBA_ALU_ADD 2'h0
`define LBA_ALU_AND 2'h1
`define LBA_ALU_BCLR 2'h2
`define LBA_ALU_BSET 2'h3

// ----------------------------------------
// destination select and reset values
// ----------------------------------------
`define LBA_DEST_ACC 1'h0
`define LBA_DEST_FILE 1'h1
`define LBA_RST_ACC 8'h00
`define LBA_RST_FLAG 1'h0
`define LBA_RST_ADDR 7'h00
`define LBA_RST_DATA 8'h00
`define LBA_RST_INSTR 14'h0000
`define LBA_NIB_W 4

`endif

// ==== lba_alu_unit.v ====
`timescale 1ns/1ps
`include "literal_bit_alu_map.vh"

module lba_alu_unit #(
    parameter DATA_W = 8,
    parameter BIDX_W = 3
) (
    input wire [1:0] op_in,
    input wire [DATA_W-1:0] acc_in,
    input wire [DATA_W-1:0] opnd_in,
    input wire [BIDX_W-1:0] bit_idx_in,
    output reg [DATA_W-1:0] result_out,
    output reg carry_out,
    output reg digit_carry_out,
    output reg zero_out
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [DATA_W:0] add_ext;
        input [DATA_W-1:0] a;
        input [DATA_W-1:0] b;
        begin
            add_ext = {1'b0, a} + {1'b0, b};
        end
    endfunction

    function [`LBA_NIB_W:0] add_nib;
        input [`LBA_NIB_W-1:0] a;
        input [`LBA_NIB_W-1:0] b;
        begin
            add_nib = {1'b0, a} + {1'b0, b};
        end
    endfunction

    reg [DATA_W:0] sum;
    reg [`LBA_NIB_W:0] nsum;
    reg [DATA_W-1:0] mask;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    always @* begin
        sum = add_ext(acc_in, opnd_in);
        nsum = add_nib(acc_in[`LBA_NIB_W-1:0], opnd_in[`LBA_NIB_W-1:0]);
        mask = {{(DATA_W-1){1'b0}}, 1'b1} << bit_idx_in;
        carry_out = 1'b0;
        digit_carry_out = 1'b0;
        case (op_in)
            `LBA_ALU_ADD: begin
                result_out = sum[DATA_W-1:0];
                carry_out = sum[DATA_W];
                digit_carry_out = nsum[`LBA_NIB_W];
            end
            `LBA_ALU_AND: begin
                result_out = acc_in & opnd_in;
            end
            `LBA_ALU_BCLR: begin
                result_out = opnd_in & ~mask;
            end
            `LBA_ALU_BSET: begin
                result_out = opnd_in | mask;
            end
            default: begin
                result_out = opnd_in;
            end
        endcase
        zero_out = (result_out == {DATA_W{1'b0}});
    end

endmodule

// ==== lba_checker.sv ====
`timescale 1ns/1ps
// ----
// port checks
// ----
module lba_checker #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7
) (
    input wire CLK_SYS_IN,
    input wire RST_IN,
    input wire CE_IN,
    input wire READY_OUT,
    input wire FILE_RD_EN_OUT,
    input wire [ADDR_W-1:0] FILE_RD_ADDR_OUT,
    input wire FILE_WR_EN_OUT,
    input wire [ADDR_W-1:0] FILE_WR_ADDR_OUT,
    input wire [DATA_W-1:0] ACC_OUT,
    input wire CARRY_FLAG_OUT,
    input wire ZERO_FLAG_OUT,
    input wire DONE_OUT,
    input wire SKIP_OUT,
    input wire DISCARD_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    property p_rd_pulse;
        FILE_RD_EN_OUT && CE_IN |=> !FILE_RD_EN_OUT;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_rd_busy;
        FILE_RD_EN_OUT |-> !READY_OUT && !DONE_OUT;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read while idle");
    property p_rd_done;
        FILE_RD_EN_OUT && CE_IN ##1 CE_IN |=> DONE_OUT;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("file op late");
    property p_wr_pulse;
        FILE_WR_EN_OUT && CE_IN |=> !FILE_WR_EN_OUT;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    // write-back must follow its own read, never stand alone
    property p_wr_after_rd;
        $rose(FILE_WR_EN_OUT) |-> $past(FILE_RD_EN_OUT, 2);
    endproperty
    a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without read");
    property p_wr_addr;
        FILE_WR_EN_OUT |-> FILE_WR_ADDR_OUT == FILE_RD_ADDR_OUT && DONE_OUT;
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address wrong");
    property p_skip;
        SKIP_OUT |-> DONE_OUT && !FILE_WR_EN_OUT && !DISCARD_OUT;
    endproperty
    a_skip: assert property (p_skip) else $error("bad skip");
    property p_discard;
        DISCARD_OUT |-> DONE_OUT && !FILE_WR_EN_OUT && $stable(ACC_OUT)
            && $stable(CARRY_FLAG_OUT) && $stable(ZERO_FLAG_OUT);
    endproperty
    a_discard: assert property (p_discard) else $error("discard had effect");
    property p_done_ready;
        DONE_OUT |-> READY_OUT;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("done while busy");
endmodule

bind literal_bit_alu_execute lba_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .READY_OUT(READY_OUT),
    .FILE_RD_EN_OUT(FILE_RD_EN_OUT), .FILE_RD_ADDR_OUT(FILE_RD_ADDR_OUT),
    .FILE_WR_EN_OUT(FILE_WR_EN_OUT), .FILE_WR_ADDR_OUT(FILE_WR_ADDR_OUT),
    .ACC_OUT(ACC_OUT), .CARRY_FLAG_OUT(CARRY_FLAG_OUT), .ZERO_FLAG_OUT(ZERO_FLAG_OUT),
    .DONE_OUT(DONE_OUT), .SKIP_OUT(SKIP_OUT), .DISCARD_OUT(DISCARD_OUT));

// ==== lba_file_model.sv ====
`timescale 1ns/1ps
// ----
// file register array
// ----
module lba_file_model (
    input wire clk_in,
    input wire ce_in,
    input wire rd_en_in,
    input wire [6:0] rd_addr_in,
    input wire wr_en_in,
    input wire [6:0] wr_addr_in,
    input wire [7:0] wr_data_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [0:127];
    initial rd_data_out = 8'h5A;
    // data only valid one cycle after the strobe; toggling afterwards exposes late sampling
    always @(posedge clk_in) begin
        if (ce_in) begin
            if (wr_en_in) mem[wr_addr_in] <= wr_data_in;
            if (rd_en_in) rd_data_out <= mem[rd_addr_in];
            else rd_data_out <= ~rd_data_out;
        end
    end
endmodule

// ==== literal_bit_alu_execute_test.sv ====
`timescale 1ns/1ps
// ----
// bench
// ----
module literal_bit_alu_execute_test;
    logic clk = 0;
    logic rst = 1;
    logic ce = 1;
    logic ivalid = 0;
    logic [13:0] instr = 14'h0000;
    wire [7:0] rd_data, wr_data, acc;
    wire [6:0] rd_addr, wr_addr;
    wire ready, rd_en, wr_en, c_f, dc_f, z_f, done, skip, disc, unsup;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h6D12589C;
    logic [7:0] ref_mem [0:127];
    logic [7:0] r_acc = 8'h00;
    logic r_c = 0, r_dc = 0, r_z = 0;
    bit pend = 0;

    literal_bit_alu_execute dut (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .INSTR_VALID_IN(ivalid), .INSTR_IN(instr), .FILE_RD_DATA_IN(rd_data),
        .READY_OUT(ready), .FILE_RD_EN_OUT(rd_en), .FILE_RD_ADDR_OUT(rd_addr),
        .FILE_WR_EN_OUT(wr_en), .FILE_WR_ADDR_OUT(wr_addr), .FILE_WR_DATA_OUT(wr_data),
        .ACC_OUT(acc), .CARRY_FLAG_OUT(c_f), .DIGIT_CARRY_FLAG_OUT(dc_f),
        .ZERO_FLAG_OUT(z_f), .DONE_OUT(done), .SKIP_OUT(skip), .DISCARD_OUT(disc),
        .UNSUPPORTED_OUT(unsup));
    lba_file_model fm (.clk_in(clk), .ce_in(ce), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
        .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_data_out(rd_data));

    initial forever #12.5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // reference: work out the outcome, then offer the word and wait for completion
    task automatic exec(input logic [13:0] w, input bit st);
        logic [8:0] s;
        logic [7:0] op, m, res;
        logic [2:0] b;
        bit wr, sk, un, fop, add;
        int n;
        m = ref_mem[w[6:0]];
        b = w[9:7];
        res = r_acc;
        {wr, sk, un} = 0;
        fop = w[13:12] == 2'h0;
        add = w[13:9] == 5'h1F || w[13:8] == 6'h07;
        if (pend) begin
        end else if (add || w[13:8] == 6'h39 || w[13:8] == 6'h05) begin
            op = fop ? m : w[7:0];
            s = r_acc + op;
            res = add ? s[7:0] : r_acc & op;
            if (add) r_c = s[8];
            if (add) r_dc = (r_acc[3:0] + op[3:0]) > 15;
            r_z = res == 8'h00;
            if (fop && w[7]) wr = 1;
            else r_acc = res;
        end else if (w[13:12] == 2'h1) begin
            res = m;
            res[b] = w[10];
            if (!w[11]) wr = 1;
            else sk = m[b] == w[10];
        end else un = 1;
        if (wr) ref_mem[w[6:0]] = res;
        @(posedge clk);
        ivalid <= 1;
        instr <= w;
        if (st) begin
            ce <= 0;
            repeat (3) @(posedge clk);
            ce <= 1;
        end
        @(posedge clk);
        ivalid <= 0;
        n = 0;
        #1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(done, 1);
        chk(unsup, un);
        chk(wr_en, wr);
        chk(skip, sk);
        chk(disc, pend);
        chk(acc, r_acc);
        chk({c_f, dc_f, z_f}, {r_c, r_dc, r_z});
        if (wr) chk({wr_addr, wr_data}, {w[6:0], res});
        pend = sk;
    endtask

    function automatic logic [13:0] gen();
        logic [31:0] r;
        r = rnd();
        case (r[31:28] % 9)
            0: return {5'h1F, r[8:0]};
            1: return {6'h39, r[7:0]};
            2: return {6'h07, r[7:0]};
            3: return {6'h05, r[7:0]};
            8: return {6'h0A, r[7:0]};
            default: return {2'h1, 2'(r[31:28] - 4), r[9:0]};
        endcase
    endfunction

    task automatic do_reset();
        int n;
        @(posedge clk);
        rst <= 1;
        repeat (8) @(posedge clk);
        #1;
        chk({acc, c_f, dc_f, z_f, ready, done}, 0);
        @(posedge clk);
        rst <= 0;
        {r_acc, r_c, r_dc, r_z, pend} = 0;
        n = 0;
        while (ready !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        logic [31:0] v;
        for (int i = 0; i < 128; i++) begin
            v = rnd();
            ref_mem[i] = v[7:0];
            fm.mem[i] = v[7:0];
        end
        do_reset();
        exec(14'h3900, 0);
        exec(14'h3EFF, 0);
        exec(14'h3F01, 1);
        $display("directed test done");
        for (int i = 0; i < 400; i++) begin
            v = rnd();
            exec(gen(), v[3:0] == 4'h0);
        end
        $display("random test done");
        do_reset();
        for (int i = 0; i < 40; i++) exec(gen(), 0);
        $display("reset test done");
        close_out();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            close_out();
        end
    end
endmodule
